// ===== src/tmo_pkg.sv
// Constants and types shared by the timer match-flag and output-select block.
// Assumes an APB slave with 32-bit data and byte addresses.
package tmo_pkg;

  // Register byte offsets
  localparam logic [7:0] TMO_OFS_CSR      = 8'h00;
  localparam logic [7:0] TMO_OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] TMO_OFS_IRQ_EN   = 8'h08;
  localparam logic [7:0] TMO_OFS_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] TMO_OFS_OBSERVE  = 8'h10;
  localparam int         TMO_ADDR_W       = 8;

  // Control/status field positions
  localparam int TMO_CSR_W       = 8;
  localparam int TMO_BIT_MATCH_B = 7;
  localparam int TMO_BIT_MATCH_A = 6;
  localparam int TMO_BIT_WRAP    = 5;
  localparam int TMO_BIT_RSVD    = 4;
  localparam int TMO_SEL_B_HI    = 3;
  localparam int TMO_SEL_B_LO    = 2;
  localparam int TMO_SEL_A_HI    = 1;
  localparam int TMO_SEL_A_LO    = 0;
  localparam logic TMO_RSVD_VAL  = 1'b1;

  // Interrupt event positions
  localparam int TMO_IRQ_W       = 3;
  localparam int TMO_EV_MATCH_A  = 0;
  localparam int TMO_EV_WRAP     = 1;
  localparam int TMO_EV_MATCH_B  = 2;

  // Output select encodings
  localparam logic [1:0] TMO_OS_KEEP   = 2'h0;
  localparam logic [1:0] TMO_OS_LOW    = 2'h1;
  localparam logic [1:0] TMO_OS_HIGH   = 2'h2;
  localparam logic [1:0] TMO_OS_TOGGLE = 2'h3;

  // Reset values
  localparam logic [1:0]  TMO_SEL_RST  = 2'h0;
  localparam logic        TMO_FLAG_RST = 1'b0;
  localparam logic        TMO_PIN_RST  = 1'b0;
  localparam logic [31:0] TMO_ZERO32   = 32'h0000_0000;

  // Default counter width
  localparam int TMO_CNT_W = 8;

  typedef logic [1:0] tmo_sel_t;

endpackage

// ===== src/tmo_match_det.sv
// Equality detector between the timer count and one compare constant.
// Assumes count and constant come from logic on the same clock.
`timescale 1ns/1ps
module tmo_match_det
  import tmo_pkg::*;
#(
  parameter int CNT_W = TMO_CNT_W
) (
  input  wire logic             pclk,      // Bus and timer clock
  input  wire logic             presetn,   // Async reset, active low
  input  wire logic [CNT_W-1:0] count,     // Timer count
  input  wire logic [CNT_W-1:0] constant,  // Compare constant
  output logic                  match,     // Level: count equals constant
  output logic                  match_ev   // Pulse: first cycle of equality
);

  typedef struct packed {
    logic prev_match;
  } tmo_det_s;

  tmo_det_s st_r;
  tmo_det_s st_nxt;

  assign match    = (count == constant);
  assign match_ev = match & ~st_r.prev_match;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.prev_match = match;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ===== src/tmo_match_flags.sv
// Control/status register of an 8-bit timer: match and wrap flags,
// output-select bits driving the match output pin, interrupt registers.
// Assumes the counter and compare constants are on pclk; APB master on pclk.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// R1: The match A flag is set whenever the timer count equals compare constant A.
// R2: The match A flag clears only on a write of 0 after a read that returned it as 1.
// R3: The wrap flag is set when the timer count goes from its maximum to zero.
// R4: The wrap flag clears only on a write of 0 after a read that returned it as 1.
// R5: Bit 4 of the control/status register always reads as 1.
// R6: On a match with constant B, bits 3:2 keep, drive low, drive high or toggle the pin.
// R7: On a match with constant A, bits 1:0 keep, drive low or drive high the pin.
// R8: The wrap flag and the four select bits reset to 0 and are software accessible.
// R9: Bits 1:0 at 11 toggle the pin on each match with constant A.
module tmo_match_flags
  import tmo_pkg::*;
#(
  parameter int CNT_W = TMO_CNT_W
) (
  input  wire logic                  pclk,                // Clock, 10 MHz
  input  wire logic                  presetn,             // Async reset, active low
  input  wire logic                  psel,                // APB select
  input  wire logic                  penable,             // APB access phase
  input  wire logic                  pwrite,              // APB direction, 1 write
  input  wire logic [TMO_ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [31:0]           pwdata,              // APB write data
  input  wire logic [3:0]            pstrb,               // APB write strobes
  output logic [31:0]                prdata,              // APB read data
  output logic                       pready,              // APB ready
  output logic                       pslverr,             // APB error, unmapped
  input  wire logic [CNT_W-1:0]      timer_count,         // Timer count
  input  wire logic [CNT_W-1:0]      compare_constant_a,  // Compare constant A
  input  wire logic [CNT_W-1:0]      compare_constant_b,  // Compare constant B
  output logic                       match_output_pin,    // Timer output pin
  output logic                       irq                  // Level interrupt
);

  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  typedef struct packed {
    tmo_sel_t               sel_a;
    tmo_sel_t               sel_b;
    logic                   match_a_flag;
    logic                   wrap_flag;
    logic                   arm_a;
    logic                   arm_wrap;
    logic                   pin;
    logic [TMO_IRQ_W-1:0]   irq_stat;
    logic [TMO_IRQ_W-1:0]   irq_en;
    logic [CNT_W-1:0]       prev_count;
    logic                   prev_valid;
    logic [31:0]            rdata;
    logic                   err;
  } tmo_state_s;

  tmo_state_s st_r;
  tmo_state_s st_nxt;

  logic [1:0] match_lvl;
  logic [1:0] match_ev;
  logic [CNT_W-1:0] cmp_const [2];

  assign cmp_const[0] = compare_constant_a;
  assign cmp_const[1] = compare_constant_b;

  // One detector per compare constant
  generate
    for (genvar g = 0; g < 2; g++) begin : g_det
      tmo_match_det #(
        .CNT_W    (CNT_W)
      ) u_det (
        .pclk     (pclk),
        .presetn  (presetn),
        .count    (timer_count),
        .constant (cmp_const[g]),
        .match    (match_lvl[g]),
        .match_ev (match_ev[g])
      );
    end
  endgenerate

  // Pin action for one select code
  function automatic logic pin_action(input tmo_sel_t sel, input logic cur);
    logic res;
    res = cur;
    unique case (sel)
      TMO_OS_KEEP:   res = cur;
      TMO_OS_LOW:    res = 1'b0;
      TMO_OS_HIGH:   res = 1'b1;
      TMO_OS_TOGGLE: res = ~cur;
    endcase
    return res;
  endfunction

  logic                 setup_ph;
  logic                 access_ph;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 hit_csr;
  logic                 hit_stat;
  logic                 hit_en;
  logic                 hit_clr;
  logic                 hit_obs;
  logic                 mapped;
  logic                 wrap_ev;
  logic                 csr_wr;
  logic                 clr_a;
  logic                 clr_wrap;
  logic [TMO_IRQ_W-1:0] events;
  logic [TMO_CSR_W-1:0] csr_view;
  logic                 pin_tmp;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;
  assign hit_csr   = (paddr == TMO_OFS_CSR);
  assign hit_stat  = (paddr == TMO_OFS_IRQ_STAT);
  assign hit_en    = (paddr == TMO_OFS_IRQ_EN);
  assign hit_clr   = (paddr == TMO_OFS_IRQ_CLR);
  assign hit_obs   = (paddr == TMO_OFS_OBSERVE);
  assign mapped    = hit_csr | hit_stat | hit_en | hit_clr | hit_obs;

  // Count wrap from all ones to zero, seen across consecutive cycles
  assign wrap_ev = st_r.prev_valid & (st_r.prev_count == CNT_MAX)  // [R3]
                 & (timer_count == CNT_ZERO);

  assign events[TMO_EV_MATCH_A] = match_ev[0];
  assign events[TMO_EV_WRAP]    = wrap_ev;
  assign events[TMO_EV_MATCH_B] = match_ev[1];

  assign csr_wr   = wr_acc & hit_csr & pstrb[0];
  // Clear only after the flag was returned as 1 by a read
  assign clr_a    = csr_wr & ~pwdata[TMO_BIT_MATCH_A] & st_r.arm_a;     // [R2]
  assign clr_wrap = csr_wr & ~pwdata[TMO_BIT_WRAP] & st_r.arm_wrap;     // [R4]

  always_comb begin
    csr_view                  = '0;
    csr_view[TMO_BIT_MATCH_B] = 1'b0;
    csr_view[TMO_BIT_MATCH_A] = st_r.match_a_flag;
    csr_view[TMO_BIT_WRAP]    = st_r.wrap_flag;
    csr_view[TMO_BIT_RSVD]    = TMO_RSVD_VAL;                            // [R5]
    csr_view[TMO_SEL_B_HI:TMO_SEL_B_LO] = st_r.sel_b;                    // [R8]
    csr_view[TMO_SEL_A_HI:TMO_SEL_A_LO] = st_r.sel_a;
  end

  always_comb begin
    st_nxt  = st_r;
    pin_tmp = st_r.pin;

    // Wrap detection history
    st_nxt.prev_count = timer_count;
    st_nxt.prev_valid = 1'b1;

    // Flags: a set in the clearing cycle wins
    st_nxt.match_a_flag = match_lvl[0] | (st_r.match_a_flag & ~clr_a);  // [R1] [R2]
    st_nxt.wrap_flag    = wrap_ev | (st_r.wrap_flag & ~clr_wrap);       // [R3] [R4]

    // Arm on read data returned; a control/status write with pstrb[0] set disarms
    if (rd_acc & hit_csr) begin
      st_nxt.arm_a    = st_r.rdata[TMO_BIT_MATCH_A];                     // [R2]
      st_nxt.arm_wrap = st_r.rdata[TMO_BIT_WRAP];                        // [R4]
    end else if (csr_wr) begin
      st_nxt.arm_a    = 1'b0;
      st_nxt.arm_wrap = 1'b0;
    end

    // Select bits
    if (csr_wr) begin
      st_nxt.sel_b = pwdata[TMO_SEL_B_HI:TMO_SEL_B_LO];                  // [R8]
      st_nxt.sel_a = pwdata[TMO_SEL_A_HI:TMO_SEL_A_LO];
    end

    // Pin: A action first, then B action on the result
    if (match_ev[0]) begin
      pin_tmp = pin_action(st_r.sel_a, pin_tmp);                         // [R7] [R9]
    end
    if (match_ev[1]) begin
      pin_tmp = pin_action(st_r.sel_b, pin_tmp);                         // [R6]
    end
    st_nxt.pin = pin_tmp;

    // Interrupt enable and sticky status; set wins over clear
    if (wr_acc & hit_en & pstrb[0]) begin
      st_nxt.irq_en = pwdata[TMO_IRQ_W-1:0];
    end
    if (wr_acc & hit_clr & pstrb[0]) begin
      st_nxt.irq_stat = events | (st_r.irq_stat & ~pwdata[TMO_IRQ_W-1:0]);
    end else begin
      st_nxt.irq_stat = events | st_r.irq_stat;
    end

    // Read data and error prepared in the setup cycle
    if (setup_ph) begin
      st_nxt.rdata = TMO_ZERO32;
      st_nxt.err   = ~mapped;
      if (!pwrite) begin
        if (hit_csr) begin
          st_nxt.rdata[TMO_CSR_W-1:0] = csr_view;
        end else if (hit_stat) begin
          st_nxt.rdata[TMO_IRQ_W-1:0] = st_r.irq_stat;
        end else if (hit_en) begin
          st_nxt.rdata[TMO_IRQ_W-1:0] = st_r.irq_en;
        end else if (hit_obs) begin
          st_nxt.rdata[CNT_W-1:0]         = timer_count;
          st_nxt.rdata[2*CNT_W-1:CNT_W]   = compare_constant_a;
          st_nxt.rdata[3*CNT_W-1:2*CNT_W] = compare_constant_b;
        end
      end
    end else begin
      // Held through the access cycle only, zero again after it
      st_nxt.rdata = TMO_ZERO32;
      st_nxt.err   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r              <= '0;
      st_r.sel_a        <= TMO_SEL_RST;                                  // [R8]
      st_r.sel_b        <= TMO_SEL_RST;
      st_r.match_a_flag <= TMO_FLAG_RST;
      st_r.wrap_flag    <= TMO_FLAG_RST;
      st_r.pin          <= TMO_PIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata           = st_r.rdata;
  assign pready           = access_ph;
  assign pslverr          = access_ph & st_r.err;
  assign match_output_pin = st_r.pin;
  assign irq              = |(st_r.irq_stat & st_r.irq_en);

endmodule

// ===== sim/tmo_match_flags_props.sv
// Checker for the timer match-flag block, bound to its ports.
// Assumes zero-wait APB and a registered match output pin.
`timescale 1ns/1ps
module tmo_match_flags_props
  import tmo_pkg::*;
#(
  parameter int CNT_W = TMO_CNT_W
) (
  input wire logic                  pclk,                // Clock
  input wire logic                  presetn,             // Reset, active low
  input wire logic                  psel,                // Select
  input wire logic                  penable,             // Access phase
  input wire logic                  pwrite,              // Direction
  input wire logic [TMO_ADDR_W-1:0] paddr,               // Address
  input wire logic [31:0]           pwdata,              // Write data
  input wire logic [3:0]            pstrb,               // Strobes
  input wire logic [31:0]           prdata,              // Read data
  input wire logic                  pready,              // Ready
  input wire logic                  pslverr,             // Error
  input wire logic [CNT_W-1:0]      timer_count,         // Count
  input wire logic [CNT_W-1:0]      compare_constant_a,  // Constant A
  input wire logic [CNT_W-1:0]      compare_constant_b,  // Constant B
  input wire logic                  match_output_pin,    // Pin
  input wire logic                  irq                  // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic eq_a_q;
  logic eq_b_q;
  wire logic eq_a = timer_count == compare_constant_a;
  wire logic eq_b = timer_count == compare_constant_b;
  wire logic acc = psel && penable;
  wire logic rd_csr = acc && !pwrite && paddr == TMO_OFS_CSR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_a_q <= 1'b0;
      eq_b_q <= 1'b0;
    end else begin
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
    end
  end
  property p_ready; pready == acc; endproperty
  a_ready: assert property (p_ready) else $error("pready wrong");
  property p_err_q; pslverr |-> pready; endproperty
  a_err_q: assert property (p_err_q) else $error("pslverr outside access");
  property p_idle; !acc |-> prdata == TMO_ZERO32; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero");
  property p_rsvd; rd_csr |-> prdata[TMO_BIT_RSVD] && prdata[31:7] == 25'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_pin; $changed(match_output_pin) |-> $past(eq_a && !eq_a_q || eq_b && !eq_b_q);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved without match");
  property p_flag_a; rd_csr && $past(eq_a, 2) |-> prdata[TMO_BIT_MATCH_A]; endproperty
  a_flag_a: assert property (p_flag_a) else $error("match flag not set");
  property p_wrap;
    rd_csr && $past(timer_count == 0, 2) && $past(timer_count == 8'hFF, 3)
      |-> prdata[TMO_BIT_WRAP];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");
  property p_map; acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > TMO_OFS_OBSERVE); endproperty
  a_map: assert property (p_map) else $error("pslverr decode wrong");
  c_flag: cover property (rd_csr && prdata[TMO_BIT_MATCH_A]);
  c_wrap: cover property (rd_csr && prdata[TMO_BIT_WRAP]);
  c_pin: cover property ($changed(match_output_pin));
endmodule

// ===== sim/tb.sv
// Self-checking bench: APB register tests and timer match stimulus.
// Assumes zero-wait slave; master waits on pready, the watchdog bounds the run.
`timescale 1ns/1ps
module tb;
  import tmo_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, match_output_pin, irq, er;
  logic [7:0]  timer_count = 8'h55, compare_constant_a = 8'h20, compare_constant_b = 8'h30;
  logic        pin_exp = 1'b0;
  logic [1:0]  m;
  int          errors = 0, cmp_count = 0;
  always #50 pclk = ~pclk;
  tmo_match_flags u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
    .compare_constant_a(compare_constant_a), .compare_constant_b(compare_constant_b),
    .match_output_pin(match_output_pin), .irq(irq));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, e, rd);
  endtask
  task automatic hit(input logic [7:0] v);
    @(posedge pclk);
    timer_count <= v;
    @(posedge pclk);
    timer_count <= 8'h55;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic end_sim;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(TMO_OFS_CSR, 32'h0000_0010, "csr_rst");
    rc(TMO_OFS_IRQ_EN, 32'h0000_0000, "en_rst");
    apb(1'b1, TMO_OFS_CSR, 32'h0000_000F, 4'h0);
    rc(TMO_OFS_CSR, 32'h0000_0010, "csr_nostrb");
    wr(TMO_OFS_CSR, 32'h0000_00FF);
    rc(TMO_OFS_CSR, 32'h0000_001F, "csr_rw");
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 4; i++) begin
        // Code orders chosen so every driving action moves the pin
        m = 2'((s == 0 ? 8'hD2 : 8'hE1) >> (2 * i));
        wr(TMO_OFS_CSR, 32'(m) << (2 * s));
        hit(s == 0 ? compare_constant_a : compare_constant_b);
        pin_exp = m == TMO_OS_KEEP ? pin_exp : m == TMO_OS_LOW ? 1'b0 :
                  m == TMO_OS_HIGH ? 1'b1 : !pin_exp;
        chk("pin", 32'(pin_exp), 32'(match_output_pin));
      end
    end
    wr(TMO_OFS_IRQ_CLR, 32'h0000_0007);
    rc(TMO_OFS_IRQ_STAT, 32'h0000_0000, "stat_clr");
    hit(compare_constant_a);
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    rc(TMO_OFS_IRQ_STAT, 32'h0000_0001, "stat_a");
    wr(TMO_OFS_IRQ_EN, 32'h0000_0001);
    @(negedge pclk);
    chk("irq_on", 32'h0000_0001, 32'(irq));
    wr(TMO_OFS_IRQ_CLR, 32'h0000_0001);
    @(negedge pclk);
    chk("irq_off", 32'h0000_0000, 32'(irq));
    wr(TMO_OFS_CSR, 32'h0000_0000);
    rc(TMO_OFS_CSR, 32'h0000_0050, "a_kept");
    @(posedge pclk);
    compare_constant_a <= 8'h00;
    timer_count <= 8'hFF;
    @(posedge pclk);
    timer_count <= 8'h00;
    rc(TMO_OFS_CSR, 32'h0000_0070, "flags_set");
    timer_count <= 8'h55;
    compare_constant_a <= 8'h20;
    wr(TMO_OFS_CSR, 32'h0000_0000);
    rc(TMO_OFS_CSR, 32'h0000_0010, "flags_clr");
    rc(TMO_OFS_OBSERVE, 32'h0030_2055, "observe");
    apb(1'b0, 8'h40, 32'h0000_0000, 4'h0);
    chk("unmapped_err", 32'h0000_0001, 32'(er));
    chk("unmapped_data", 32'h0000_0000, rd);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim;
  end
endmodule
bind tmo_match_flags tmo_match_flags_props #(.CNT_W(CNT_W)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_count(timer_count), .compare_constant_a(compare_constant_a),
  .compare_constant_b(compare_constant_b), .match_output_pin(match_output_pin), .irq(irq));
